// [core/srpc_pkg.sv]
// How it works
// - request comes from software bit or pin; pin uses level, rising or falling trigger
// - generator ticks on second loop feedback when select is 0, first loop output when 1
// - external resample uses device clock when select is 0, first loop output when 1
// - test code 00 drives low, 01 drives high, 1x drives counter clock
// - source 00 external, 01 external resampled, 10 internal generator
// - mode 00 n-shot, 01 continuous, 10 prbs, 11 stop; count codes give pulses
// - n-shot starts on request bit rising, bit clears itself when pattern ends
// - continuous or prbs starts on request bit rising, bit stays set
// - software clearing request bit stops continuous or prbs pattern at once
// - sixteen-bit two-byte divider sets width of each pulse
package srpc_pkg;
  localparam logic [15:0] ADDR_K_LO = 16'h0400;
  localparam logic [15:0] ADDR_K_HI = 16'h0401;
  localparam logic [15:0] ADDR_CTL_A = 16'h0402;
  localparam logic [15:0] ADDR_CTL_B = 16'h0403;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int A_METHOD = 7;
  localparam int A_TRIG_HI = 6;
  localparam int A_TRIG_LO = 5;
  localparam int A_GEN_SEL = 4;
  localparam int A_RS_SEL = 3;
  localparam int A_TEST_HI = 2;
  localparam int A_TEST_LO = 1;
  localparam int A_RESET = 0;
  localparam int B_SRC_HI = 7;
  localparam int B_SRC_LO = 6;
  localparam int B_MODE_HI = 5;
  localparam int B_MODE_LO = 4;
  localparam int B_CNT_HI = 3;
  localparam int B_CNT_LO = 1;
  localparam int B_REQ = 0;
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_RESAMP = 2'h1;
  localparam logic [1:0] SRC_INT = 2'h2;
  localparam logic [1:0] MODE_NSHOT = 2'h0;
  localparam logic [1:0] MODE_CONT = 2'h1;
  localparam logic [1:0] MODE_PRBS = 2'h2;
  localparam logic [1:0] MODE_STOP = 2'h3;
  localparam logic [1:0] TEST_LOW = 2'h0;
  localparam logic [1:0] TEST_HIGH = 2'h1;
  localparam logic [1:0] TRIG_RISE = 2'h2;
  localparam logic [1:0] TRIG_FALL = 2'h3;
  localparam logic [6:0] LFSR_SEED = 7'h7f;
  localparam logic [15:0] K_MIN = 16'h0001;
  localparam logic [3:0] PULSE_ONE = 4'h1;
  typedef enum logic [1:0] {
    SRPC_IDLE = 2'b00,
    SRPC_RUN = 2'b01
  } srpc_state_e;
  function automatic logic [3:0] srpc_target(input logic [2:0] code);
    case (code)
      3'h2: srpc_target = 4'h2;
      3'h3: srpc_target = 4'h4;
      3'h4: srpc_target = 4'h6;
      3'h5: srpc_target = 4'h8;
      default: srpc_target = PULSE_ONE;
    endcase
  endfunction
endpackage

// [core/srpc_top.sv]
`timescale 1ns/1ps
module srpc_top (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic wr_en_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic req_pin_i,
  input wire logic ext_sysref_i,
  input wire logic dev_clk_i,
  input wire logic pll1_out_i,
  input wire logic pll2_fb_i,
  output logic sysref_o
);
  import srpc_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [7:0] k_lo;
    logic [7:0] k_hi;
    logic req_q;
    logic pin_q;
    logic gen_clk_q;
    logic rs_clk_q;
    srpc_state_e st;
    logic [15:0] div;
    logic half;
    logic [3:0] pulses;
    logic [6:0] lfsr;
    logic resamp;
    logic sysref;
    logic [7:0] rdata;
  } srpc_s;

  srpc_s s;
  srpc_s next_s;
  logic gen_clk;
  logic rs_clk;
  logic gen_tick;
  logic rs_tick;
  logic start;
  logic hold;
  logic [1:0] mode;
  logic [1:0] trig;
  logic [15:0] k_val;
  logic [3:0] target;
  logic pat;

  // ==========================================================
  // trigger and clock selection
  always_comb begin
    mode = s.ctl_b[B_MODE_HI:B_MODE_LO];
    trig = s.ctl_a[A_TRIG_HI:A_TRIG_LO];
    gen_clk = s.ctl_a[A_GEN_SEL] ? pll1_out_i : pll2_fb_i;
    rs_clk = s.ctl_a[A_RS_SEL] ? pll1_out_i : dev_clk_i;
    gen_tick = gen_clk & ~s.gen_clk_q;
    rs_tick = rs_clk & ~s.rs_clk_q;
    k_val = ({s.k_hi, s.k_lo} < K_MIN) ? K_MIN : {s.k_hi, s.k_lo};
    target = srpc_target(s.ctl_b[B_CNT_HI:B_CNT_LO]);
    if (s.ctl_a[A_METHOD]) begin
      case (trig)
        TRIG_RISE: begin
          start = req_pin_i & ~s.pin_q;
          hold = 1'b1;
        end
        TRIG_FALL: begin
          start = ~req_pin_i & s.pin_q;
          hold = 1'b1;
        end
        default: begin
          start = req_pin_i;
          hold = req_pin_i;
        end
      endcase
    end else begin
      start = s.ctl_b[B_REQ] & ~s.req_q;
      hold = s.ctl_b[B_REQ];
    end
    pat = (mode == MODE_PRBS) ? (s.half & s.lfsr[0]) : s.half;
  end

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.gen_clk_q = gen_clk;
    next_s.rs_clk_q = rs_clk;
    next_s.pin_q = req_pin_i;
    next_s.req_q = s.ctl_b[B_REQ];
    if (rs_tick) begin
      next_s.resamp = ext_sysref_i;
    end
    case (s.st)
      SRPC_IDLE: begin
        next_s.half = 1'b0;
        if (start && mode != MODE_STOP && !s.ctl_a[A_RESET]) begin
          next_s.st = SRPC_RUN;
          next_s.div = '0;
          next_s.half = 1'b1;
          next_s.pulses = '0;
        end
      end
      SRPC_RUN: begin
        if (s.ctl_a[A_RESET] || mode == MODE_STOP || (!hold && mode != MODE_NSHOT)) begin
          next_s.st = SRPC_IDLE;
          next_s.half = 1'b0;
        end else if (gen_tick) begin
          if (s.div >= k_val - K_MIN) begin
            next_s.div = '0;
            next_s.half = ~s.half;
            if (s.half) begin
              next_s.pulses = s.pulses + PULSE_ONE;
              next_s.lfsr = {s.lfsr[5:0], s.lfsr[6] ^ s.lfsr[5]};
              if (mode == MODE_NSHOT && s.pulses + PULSE_ONE >= target) begin
                next_s.st = SRPC_IDLE;
                next_s.ctl_b[B_REQ] = 1'b0;
              end
            end
          end else begin
            next_s.div = s.div + K_MIN;
          end
        end
      end
      default: next_s.st = SRPC_IDLE;
    endcase
    case (s.ctl_b[B_SRC_HI:B_SRC_LO])
      SRC_EXT: next_s.sysref = ext_sysref_i;
      SRC_RESAMP: next_s.sysref = s.resamp;
      SRC_INT: next_s.sysref = pat;
      default: begin
        case (s.ctl_a[A_TEST_HI:A_TEST_LO])
          TEST_LOW: next_s.sysref = 1'b0;
          TEST_HIGH: next_s.sysref = 1'b1;
          default: next_s.sysref = s.half;
        endcase
      end
    endcase
    if (wr_en_i) begin
      case (addr_i)
        ADDR_K_LO: next_s.k_lo = wdata_i;
        ADDR_K_HI: next_s.k_hi = wdata_i;
        ADDR_CTL_A: next_s.ctl_a = wdata_i;
        ADDR_CTL_B: next_s.ctl_b = wdata_i;
        default: ;
      endcase
    end
    case (addr_i)
      ADDR_K_LO: next_s.rdata = s.k_lo;
      ADDR_K_HI: next_s.rdata = s.k_hi;
      ADDR_CTL_A: next_s.rdata = s.ctl_a;
      ADDR_CTL_B: next_s.rdata = s.ctl_b;
      default: next_s.rdata = RST_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      s <= '0;
      s.lfsr <= LFSR_SEED;
    end else begin
      s <= next_s;
    end
  end

  assign sysref_o = s.sysref;
  assign rdata_o = s.rdata;

  // ==========================================================
  // assertions
  sequence spi_rise_s;
    !s.ctl_a[A_METHOD] && s.ctl_b[B_REQ] && !s.req_q;
  endsequence
  sequence idle_ok_s;
    s.st == SRPC_IDLE && !s.ctl_a[A_RESET] && mode != MODE_STOP;
  endsequence

  a_spi_start: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (spi_rise_s and idle_ok_s) |=> s.st == SRPC_RUN) else $error("spi request missed");
  a_pin_rise: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (s.ctl_a[A_METHOD] && trig == TRIG_RISE && req_pin_i && !s.pin_q) and idle_ok_s
    |=> s.st == SRPC_RUN) else $error("pin edge missed");
  a_gen_source: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (s.st == SRPC_RUN && next_s.st == SRPC_RUN && !gen_tick) |=> $stable(s.half))
    else $error("tick without clock");
  a_resample: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (!rs_tick && s.ctl_b[B_SRC_HI:B_SRC_LO] == SRC_RESAMP) |=> $stable(s.resamp))
    else $error("resample without edge");
  a_test_high: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (s.ctl_b[B_SRC_HI:B_SRC_LO] == 2'h3 && s.ctl_a[A_TEST_HI:A_TEST_LO] == TEST_HIGH)
    |=> sysref_o) else $error("test high wrong");
  a_src_ext: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s.ctl_b[B_SRC_HI:B_SRC_LO] == SRC_EXT |=> sysref_o == $past(ext_sysref_i))
    else $error("external path wrong");
  a_pulse_cap: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (s.st == SRPC_RUN && mode == MODE_NSHOT && $stable(s.ctl_b)) |-> s.pulses < target)
    else $error("too many pulses");
  a_nshot_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (s.st == SRPC_RUN && next_s.st == SRPC_IDLE && mode == MODE_NSHOT && !wr_en_i
    && !s.ctl_a[A_RESET]) |=> !s.ctl_b[B_REQ]) else $error("request not cleared");
  a_cont_keep: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (mode == MODE_CONT && s.ctl_b[B_REQ] && !wr_en_i) |=> s.ctl_b[B_REQ])
    else $error("request cleared");
  a_cont_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (s.st == SRPC_RUN && !s.ctl_a[A_METHOD] && mode == MODE_CONT && !s.ctl_b[B_REQ])
    |=> s.st == SRPC_IDLE ##1 !sysref_o || s.ctl_b[B_SRC_HI:B_SRC_LO] != SRC_INT)
    else $error("pattern not stopped");
  a_div_width: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (s.st == SRPC_RUN && $changed(s.half) && $past(s.st) == SRPC_RUN)
    |-> $past(s.div) >= k_val - K_MIN) else $error("pulse width wrong");
  a_reset_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    s.ctl_a[A_RESET] |=> s.st == SRPC_IDLE && !s.half) else $error("reset ignored");
endmodule

// [dv/srpc_rx_model.sv]
`timescale 1ns/1ps
module srpc_rx_model (
  input wire logic sys_clk_i,
  input wire logic clr_i,
  input wire logic sysref_i,
  output logic [7:0] pulses_o
);
  logic prev;
  // ==========
  // counts sysref rising edges
  always_ff @(posedge sys_clk_i) begin
    prev <= sysref_i;
    if (clr_i) pulses_o <= 8'h00;
    else if (sysref_i && !prev) pulses_o <= pulses_o + 8'h01;
  end
endmodule

// [dv/srpc_top_tb.sv]
`timescale 1ns/1ps
module srpc_top_tb;
  import srpc_pkg::*;
  logic sys_clk_i = 0, rst_b_i = 0, wr_en_i = 0, req_pin_i = 0, ext_sysref_i = 0;
  logic dev_clk_i = 0, pll1_out_i = 0, pll2_fb_i = 0, clr = 1, sysref_o;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00, rdata_o, pulses, rd;
  logic [7:0] ns [6] = '{8'h01, 8'h01, 8'h02, 8'h04, 8'h06, 8'h08};
  int n_fail = 0, n_compared = 0, cyc = 0;
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  srpc_top i_srpc_top(.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .wr_en_i(wr_en_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .req_pin_i(req_pin_i),
    .ext_sysref_i(ext_sysref_i), .dev_clk_i(dev_clk_i), .pll1_out_i(pll1_out_i),
    .pll2_fb_i(pll2_fb_i), .sysref_o(sysref_o));
  srpc_rx_model i_srpc_rx_model(.sys_clk_i(sys_clk_i), .clr_i(clr), .sysref_i(sysref_o),
    .pulses_o(pulses));
  // ==========
  // generator clocks and timeout
  always @(negedge sys_clk_i) begin
    cyc <= cyc + 1;
    pll2_fb_i <= ~pll2_fb_i;
    pll1_out_i <= cyc[1];
    dev_clk_i <= ~dev_clk_i;
    if (cyc > 20000) begin
      n_fail++;
      conclude();
    end
  end
  task conclude();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    addr_i = a;
    wdata_i = d;
    wr_en_i = 1;
    @(negedge sys_clk_i);
    wr_en_i = 0;
  endtask
  task rdr(input logic [15:0] a);
    @(negedge sys_clk_i);
    addr_i = a;
    repeat (2) @(negedge sys_clk_i);
    rd = rdata_o;
  endtask
  task run(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task t_regs();
    rdr(ADDR_CTL_A); chk("ctl_a reset", RST_BYTE, rd);
    rdr(ADDR_CTL_B); chk("ctl_b reset", RST_BYTE, rd);
    wr(ADDR_CTL_A, 8'h0a); rdr(ADDR_CTL_A); chk("ctl_a rw", 8'h0a, rd);
    rdr(16'h0404); chk("unmapped", 8'h00, rd);
    wr(ADDR_K_LO, 8'h01); wr(ADDR_K_HI, 8'h00);
  endtask
  task t_nshot();
    for (int c = 0; c < 6; c++) begin
      wr(ADDR_CTL_A, {3'h0, c[0], 4'h0});
      clr = 1; run(1); clr = 0;
      wr(ADDR_CTL_B, {SRC_INT, MODE_NSHOT, c[2:0], 1'b1});
      rd = 8'hff;
      for (int i = 0; i < 300 && rd[0] !== 1'b0; i++) rdr(ADDR_CTL_B);
      chk("request cleared", 8'h00, {7'h0, rd[0]});
      run(4); chk("pulse count", ns[c], pulses);
    end
  endtask
  task t_cont();
    for (int m = 1; m < 3; m++) begin
      clr = 1; run(1); clr = 0;
      wr(ADDR_CTL_B, {SRC_INT, m[1:0], 4'h1}); run(80);
      rdr(ADDR_CTL_B); chk("request held", 8'h01, {7'h0, rd[0]});
      chk("pattern runs", 8'h01, {7'h0, pulses > 0});
      wr(ADDR_CTL_B, {SRC_INT, m[1:0], 4'h0}); run(3);
      chk("stopped output", 8'h00, {7'h0, sysref_o});
      clr = 1; run(1); clr = 0; run(30);
      chk("pattern stopped", 8'h00, pulses);
    end
  endtask
  task t_rst();
    wr(ADDR_CTL_A, 8'h01); clr = 1; run(1); clr = 0;
    wr(ADDR_CTL_B, {SRC_INT, MODE_NSHOT, 4'h1}); run(30);
    chk("held idle", 8'h00, pulses);
    wr(ADDR_CTL_B, 8'h00); wr(ADDR_CTL_A, 8'h00); clr = 1; run(1); clr = 0;
    wr(ADDR_CTL_B, {SRC_INT, MODE_NSHOT, 4'h1}); run(20);
    chk("resumed", 8'h01, pulses);
  endtask
  task t_ext();
    wr(ADDR_CTL_B, {SRC_EXT, 6'h0});
    for (int k = 0; k < 4; k++) begin
      ext_sysref_i = k[0]; run(1); chk("ext direct", {7'h0, k[0]}, {7'h0, sysref_o});
    end
    wr(ADDR_CTL_B, {SRC_RESAMP, 6'h0});
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTL_A, {4'h0, k[1], 3'h0}); ext_sysref_i = k[0]; run(8);
      chk("ext resampled", {7'h0, k[0]}, {7'h0, sysref_o});
    end
    wr(ADDR_CTL_B, 8'hc0); wr(ADDR_CTL_A, 8'h02); run(3);
    chk("test high", 8'h01, {7'h0, sysref_o});
    wr(ADDR_CTL_A, 8'h00); run(3); chk("test low", 8'h00, {7'h0, sysref_o});
    wr(ADDR_CTL_A, 8'h04); clr = 1; run(1); clr = 0;
    wr(ADDR_CTL_B, {2'h3, MODE_CONT, 4'h1}); run(40);
    chk("counter clock", 8'h01, {7'h0, pulses > 0});
    wr(ADDR_CTL_B, {2'h3, MODE_CONT, 4'h0}); run(3);
  endtask
  task t_pin();
    wr(ADDR_CTL_A, 8'h80); wr(ADDR_CTL_B, {SRC_INT, MODE_CONT, 4'h0});
    clr = 1; run(1); clr = 0; req_pin_i = 1; run(40);
    chk("pin level run", 8'h01, {7'h0, pulses > 0});
    req_pin_i = 0; run(5); clr = 1; run(1); clr = 0; run(20);
    chk("pin level stop", 8'h00, pulses);
    wr(ADDR_CTL_B, {SRC_INT, MODE_NSHOT, 4'h4});
    wr(ADDR_CTL_A, 8'hc0); clr = 1; run(1); clr = 0; req_pin_i = 1; run(60);
    chk("pin rising", 8'h02, pulses);
    wr(ADDR_CTL_A, 8'he0); clr = 1; run(1); clr = 0; req_pin_i = 0; run(60);
    chk("pin falling", 8'h02, pulses);
  endtask
  initial begin
    run(5);
    rst_b_i = 1;
    t_regs();
    t_nshot();
    t_cont();
    t_rst();
    t_ext();
    t_pin();
    conclude();
  end
endmodule
